// ==== src/an_lt_control_inputs.sv ====
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - An advertise bit at one advertises that protocol in the codeword
// RULE2 - Training enable low means no training and all lanes in mission mode
// RULE3 - Restart sends training back to its start from any state
// RULE4 - Host sets a lane's trained bit only once its receive training ends
// RULE5 - Per-lane preset bit is copied into that lane's frame control block
// RULE6 - Per-lane initialize bit goes into that lane's frame control block
// RULE7 - Lane 0 pattern generator is loaded from the eleven-bit seed
// RULE8 - Lane 0 post, main and pre tap update requests go into control block
// RULE9 - Lane 0 post and main tap status values go into the status block
// RULE10 - Direct pins act only when registers are not selected as source; the lane receiver trained pins act always
// RULE11 - Bit i of every four-bit lane control applies to lane i
module an_lt_control_inputs
  import an_lt_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [ADV_W-1:0]  protocol_advertise_bits,
  input  wire logic              training_enable_in,
  input  wire logic              training_restart_in,
  input  wire logic [LANES-1:0]  lane_receiver_trained,
  input  wire logic [LANES-1:0]  preset_request_out_bits,
  input  wire logic [LANES-1:0]  initialize_request_out_bits,
  input  wire logic [SEED_W-1:0] lane0_pattern_seed,
  input  wire logic [1:0]        lane0_post_tap_update,
  input  wire logic [1:0]        lane0_main_tap_update,
  input  wire logic [1:0]        lane0_pre_tap_update,
  input  wire logic [1:0]        lane0_post_tap_status,
  input  wire logic [1:0]        lane0_main_tap_status,
  output logic      [ADV_W-1:0]  codeword_advertise,
  output logic      [LANES-1:0]  frame_preset,
  output logic      [LANES-1:0]  frame_initialize,
  output logic      [COEF_W-1:0] frame_lane0_update,
  output logic      [STAT_W-1:0] frame_lane0_status,
  output logic      [LANES-1:0]  lane_mission_mode,
  output logic                   training_active,
  output logic      [SEED_W-1:0] lane0_pattern_state
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [PIN_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_acc_q, pin_acc_d;
  wire  [PIN_W-1:0] pin_raw;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign pin_raw = {protocol_advertise_bits, training_enable_in,
                    training_restart_in, lane_receiver_trained,
                    preset_request_out_bits, initialize_request_out_bits,
                    lane0_pattern_seed, lane0_post_tap_update,
                    lane0_main_tap_update, lane0_pre_tap_update,
                    lane0_post_tap_status, lane0_main_tap_status};

  // A bit is accepted once stages two and three agree
  assign pin_acc_d = ((pin_s2_q ~^ pin_s3_q) & pin_s3_q)
                   | ((pin_s2_q ^ pin_s3_q) & pin_acc_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      pin_s3_q  <= '0;
      pin_acc_q <= '0;
    end else begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_acc_q <= pin_acc_d;
    end
  end

  wire [ADV_W-1:0]  p_adv;
  wire              p_en, p_rst;
  wire [LANES-1:0]  p_rxt, p_pre, p_ini;
  wire [SEED_W-1:0] p_seed;
  wire [COEF_W-1:0] p_coef;
  wire [STAT_W-1:0] p_stat;
  assign {p_adv, p_en, p_rst, p_rxt, p_pre, p_ini,
          p_seed, p_coef, p_stat} = pin_acc_q;

  // ****************************************************************
  // Wishbone register file
  // ****************************************************************
  logic [2:0]        ctrl_q;
  logic [ADV_W-1:0]  adv_q;
  logic [7:0]        lane_q;
  logic [9:0]        coef_q;
  logic [SEED_W-1:0] seed_q;
  logic [31:0]       rd_d;
  train_state_t      state_q, state_d;

  wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack high
  wire wb_wr   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  wire wr_ctrl = wb_wr && wb_sel_i[0] && wb_adr_i == OFS_CTRL;
  wire wr_adv  = wb_wr && wb_adr_i == OFS_ADV;
  wire wr_lane = wb_wr && wb_sel_i[0] && wb_adr_i == OFS_LANE;
  wire wr_coef = wb_wr && wb_adr_i == OFS_COEF;
  wire wr_seed = wb_wr && wb_adr_i == OFS_SEED;
  wire reg_src = ctrl_q[CTRL_SRC_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  // Picks register or pin copy of a control field
  function automatic logic [15:0] pick(input logic        sel,
                                       input logic [15:0] rv,
                                       input logic [15:0] pv);
    return sel ? rv : pv;
  endfunction

  wire [31:0] adv_m  = merge({17'h0, adv_q}, wb_dat_i, wb_sel_i);
  wire [31:0] coef_m = merge({22'h0, coef_q}, wb_dat_i, wb_sel_i);
  wire [31:0] seed_m = merge({21'h0, seed_q}, wb_dat_i, wb_sel_i);

  always_comb begin
    case (wb_adr_i)
      OFS_CTRL:   rd_d = {30'h0, ctrl_q[1:0]};
      OFS_ADV:    rd_d = {17'h0, adv_q};
      OFS_LANE:   rd_d = {24'h0, lane_q};
      OFS_COEF:   rd_d = {22'h0, coef_q};
      OFS_SEED:   rd_d = {21'h0, seed_q};
      OFS_STATUS: rd_d = {25'h0, lane_mission_mode[0], p_rxt, state_q};
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q   <= RST_CTRL;
      adv_q    <= RST_ADV;
      lane_q   <= RST_LANE;
      coef_q   <= RST_COEF;
      seed_q   <= RST_SEED;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? rd_d : 32'h0000_0000;
      ctrl_q[CTRL_RESTART_BIT] <= wr_ctrl && wb_dat_i[CTRL_RESTART_BIT];
      if (wr_ctrl) ctrl_q[1:0] <= wb_dat_i[1:0];
      if (wr_adv)  adv_q  <= adv_m[ADV_W-1:0];
      if (wr_lane) lane_q <= wb_dat_i[7:0];
      if (wr_coef) coef_q <= coef_m[9:0];
      if (wr_seed) seed_q <= seed_m[SEED_W-1:0];
    end
  end

  // ****************************************************************
  // Source selection
  // ****************************************************************
  wire [15:0] adv_w  = pick(reg_src, {1'b0, adv_q}, {1'b0, p_adv}); // RULE10
  wire [15:0] lane_w = pick(reg_src, {8'h0, lane_q}, {8'h0, p_ini, p_pre});
  wire [15:0] cf_w   = pick(reg_src, {6'h0, coef_q}, {6'h0, p_coef, p_stat});
  wire [15:0] seed_w = pick(reg_src, {5'h0, seed_q}, {5'h0, p_seed});
  wire [15:0] en_w   = pick(reg_src, {15'h0, ctrl_q[CTRL_ENABLE_BIT]},
                            {15'h0, p_en});
  wire [ADV_W-1:0]  sel_adv  = adv_w[ADV_W-1:0];
  wire [LANES-1:0]  sel_pre  = lane_w[LANES-1:0];
  wire [LANES-1:0]  sel_ini  = lane_w[LANE_INIT_LSB +: LANES];
  wire [SEED_W-1:0] sel_seed = seed_w[SEED_W-1:0];
  wire [COEF_W-1:0] sel_coef = reg_src ? cf_w[COEF_W-1:0]
                                       : cf_w[STAT_W +: COEF_W];
  wire [STAT_W-1:0] sel_stat = reg_src ? cf_w[COEF_W +: STAT_W]
                                       : cf_w[STAT_W-1:0];
  wire              sel_en   = en_w[0];
  wire [LANES-1:0]  sel_rxt  = p_rxt;

  // Restart from pin edge or register pulse
  logic p_rst_prev_q;
  wire  restart_ev = reg_src ? ctrl_q[CTRL_RESTART_BIT]
                             : (p_rst && !p_rst_prev_q);

  // ****************************************************************
  // Training sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    if (!sel_en) state_d = ST_MISSION;                                 // RULE2
    else if (restart_ev) state_d = ST_LOAD;                            // RULE3
    else begin
      case (state_q)
        ST_MISSION: state_d = ST_LOAD;
        ST_LOAD:    state_d = ST_TRAIN;
        ST_TRAIN:   state_d = &sel_rxt ? ST_DONE : ST_TRAIN;           // RULE4
        ST_DONE:    state_d = ST_DONE;
        default:    state_d = ST_MISSION;
      endcase
    end
  end

  wire [SEED_W-1:0] lfsr_next = {lane0_pattern_state[SEED_W-2:0],
                                 lane0_pattern_state[10]
                                 ^ lane0_pattern_state[8]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q             <= ST_MISSION;
      p_rst_prev_q        <= 1'b0;
      lane0_pattern_state <= RST_SEED;
      codeword_advertise  <= RST_ADV;
      frame_preset        <= '0;
      frame_initialize    <= '0;
      frame_lane0_update  <= '0;
      frame_lane0_status  <= '0;
      lane_mission_mode   <= '1;
      training_active     <= 1'b0;
    end else begin
      state_q      <= state_d;
      p_rst_prev_q <= p_rst;
      if (state_d == ST_LOAD)
        lane0_pattern_state <= sel_seed;                               // RULE7
      else if (state_d == ST_TRAIN)
        lane0_pattern_state <= lfsr_next;
      codeword_advertise <= sel_adv;                                   // RULE1
      frame_preset       <= sel_pre;                        // RULE5 RULE11
      frame_initialize   <= sel_ini;                        // RULE6 RULE11
      frame_lane0_update <= sel_coef;                                  // RULE8
      frame_lane0_status <= sel_stat;                                  // RULE9
      lane_mission_mode  <= {LANES{state_d == ST_MISSION}};            // RULE2
      training_active    <= state_d == ST_LOAD || state_d == ST_TRAIN;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_restart;
    sel_en && restart_ev;
  endsequence
  sequence s_load_phase;
    state_q == ST_LOAD && lane0_pattern_state == $past(sel_seed);
  endsequence

  AST_ADVERTISE: assert property (##1 codeword_advertise // RULE1
                                  == $past(sel_adv))
    else $error("Advertise bits do not follow the selected source");
  AST_MISSION: assert property (!sel_en |=> state_q == ST_MISSION // RULE2
                                && lane_mission_mode == 4'hf
                                && !training_active)
    else $error("Lanes not in mission mode while training disabled");
  AST_RESTART: assert property (s_restart |=> s_load_phase) // RULE3
    else $error("Restart did not return training to its start");
  AST_TRAINED: assert property (state_q == ST_TRAIN && !(&sel_rxt) // RULE4
                                |=> state_q != ST_DONE)
    else $error("Training finished before all lanes were trained");
  AST_PRESET: assert property (##1 frame_preset == $past(sel_pre)) // RULE5
    else $error("Preset bits not copied into the frame");
  AST_INIT: assert property (##1 frame_initialize == $past(sel_ini)) // RULE6
    else $error("Initialize bits not copied into the frame");
  AST_SEED: assert property (state_d == ST_LOAD |=> s_load_phase) // RULE7
    else $error("Pattern generator not loaded from the seed");
  AST_COEF: assert property (##1 frame_lane0_update // RULE8
                             == $past(sel_coef))
    else $error("Lane 0 update fields wrong");
  AST_STATUS: assert property (##1 frame_lane0_status // RULE9
                               == $past(sel_stat))
    else $error("Lane 0 status fields wrong");
  AST_SOURCE: assert property (!reg_src |=> frame_preset // RULE10
                                == $past(p_pre))
    else $error("Pin values ignored while registers not selected");
  AST_LANE_MAP: assert property (##1 frame_initialize[3] // RULE11
                                 == $past(sel_ini[3]))
    else $error("Lane 3 initialize bit mapped wrong");
  AST_ACK: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single-cycle answer");

endmodule

// ==== src/an_lt_ctrl_pkg.sv ====
package an_lt_ctrl_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADV_W   = 15;
  localparam int LANES   = 4;
  localparam int SEED_W  = 11;
  localparam int COEF_W  = 6;
  localparam int STAT_W  = 4;
  localparam int PIN_W   = ADV_W + 2 + 3 * LANES + SEED_W + COEF_W + STAT_W;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADV    = 8'h04;
  localparam logic [7:0] OFS_LANE   = 8'h08;
  localparam logic [7:0] OFS_COEF   = 8'h0c;
  localparam logic [7:0] OFS_SEED   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SRC_BIT     = 0;
  localparam int CTRL_ENABLE_BIT  = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int LANE_INIT_LSB    = 4;
  localparam int STATUS_RXT_LSB   = 2;
  localparam int STATUS_MISS_BIT  = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0]        RST_CTRL = 3'h0;
  localparam logic [ADV_W-1:0]  RST_ADV  = 15'h0000;
  localparam logic [7:0]        RST_LANE = 8'h00;
  localparam logic [9:0]        RST_COEF = 10'h000;
  localparam logic [SEED_W-1:0] RST_SEED = 11'h001;

  typedef enum logic [1:0] {
    ST_MISSION,
    ST_LOAD,
    ST_TRAIN,
    ST_DONE
  } train_state_t;

endpackage

// ==== verification/host_partner.sv ====
`timescale 1ns/10ps
module host_partner (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       training_active,
  output logic      [3:0] lane_receiver_trained
);
  // ****************************************************************
  // Receive-side training of the host, one lane after another
  // ****************************************************************
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;

  assign cnt_d = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q                 <= 6'h00;
      lane_receiver_trained <= 4'h0;
    end else if (!training_active) begin
      cnt_q                 <= 6'h00;
      lane_receiver_trained <= 4'h0;
    end else begin
      cnt_q                 <= cnt_d;
      lane_receiver_trained <= {cnt_q >= 6'h18, cnt_q >= 6'h14,
                                cnt_q >= 6'h10, cnt_q >= 6'h0c};
    end
  end
endmodule

// ==== verification/tb_an_lt_control_inputs.sv ====
`timescale 1ns/10ps
module tb_an_lt_control_inputs;
  import an_lt_ctrl_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       dat = 32'h0;
  logic [31:0]       q;
  logic [ADV_W-1:0]  adv = '0;
  logic              ten = 1'b0;
  logic              trs = 1'b0;
  logic [LANES-1:0]  pre = '0;
  logic [LANES-1:0]  ini = '0;
  logic [SEED_W-1:0] seed = 11'h001;
  logic [COEF_W-1:0] upd = '0;
  logic [STAT_W-1:0] sts = '0;
  logic [LANES-1:0]  trn, fp, fi, mm;
  logic [ADV_W-1:0]  cw;
  logic [COEF_W-1:0] fu;
  logic [STAT_W-1:0] fs;
  logic [SEED_W-1:0] pst;
  logic [31:0]       dat_o;
  logic              ack, act;
  int                fail_count = 0;
  int                num_checks = 0;

  always #4 clk = ~clk;

  an_lt_control_inputs dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .protocol_advertise_bits(adv), .training_enable_in(ten),
    .training_restart_in(trs), .lane_receiver_trained(trn),
    .preset_request_out_bits(pre), .initialize_request_out_bits(ini),
    .lane0_pattern_seed(seed), .lane0_post_tap_update(upd[5:4]),
    .lane0_main_tap_update(upd[3:2]), .lane0_pre_tap_update(upd[1:0]),
    .lane0_post_tap_status(sts[3:2]), .lane0_main_tap_status(sts[1:0]),
    .codeword_advertise(cw), .frame_preset(fp), .frame_initialize(fi),
    .frame_lane0_update(fu), .frame_lane0_status(fs),
    .lane_mission_mode(mm), .training_active(act),
    .lane0_pattern_state(pst));

  host_partner host_u (.clk(clk), .reset_n(reset_n),
    .training_active(act), .lane_receiver_trained(trn));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      print_verdict;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wait_act(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (act !== v && n < 80);
    if (n >= 80) begin
      fail_count++;
      print_verdict;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    chk("mission", 32'hf, mm);
    chk("active", 32'h0, act);
    chk("pattern", 32'h1, pst);
    $display("test reset done");
  endtask

  task t_pins;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      adv <= k ? 15'h2d56 : 15'h52a9;
      pre <= k ? 4'he : 4'h1;
      ini <= k ? 4'h7 : 4'h8;
      upd <= k ? 6'h18 : 6'h27;
      sts <= k ? 4'h6 : 4'h9;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("codeword", k ? 32'h2d56 : 32'h52a9, cw);
      chk("preset", k ? 32'he : 32'h1, fp);
      chk("init", k ? 32'h7 : 32'h8, fi);
      chk("update", k ? 32'h18 : 32'h27, fu);
      chk("status", k ? 32'h6 : 32'h9, fs);
    end
    $display("test pins done");
  endtask

  task t_train;
    @(posedge clk);
    seed <= 11'h5a3;
    ten  <= 1'b1;
    wait_act(1'b1);
    chk("seed load", 32'h5a3, pst);
    chk("mission off", 32'h0, mm);
    wait_act(1'b0);
    @(posedge clk);
    seed <= 11'h2c6;
    trs  <= 1'b1;
    wait_act(1'b1);
    chk("restart seed", 32'h2c6, pst);
    @(posedge clk);
    trs <= 1'b0;
    ten <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("mission on", 32'hf, mm);
    chk("idle", 32'h0, act);
    $display("test train done");
  endtask

  task t_regs;
    wb(1'b1, OFS_SEED, 32'h3c5);
    wb(1'b1, OFS_CTRL, 32'h3);
    wait_act(1'b1);
    chk("reg seed", 32'h3c5, pst);
    wb(1'b1, OFS_CTRL, 32'h7);
    repeat (2) @(negedge clk);
    chk("reg restart", 32'h3c5, pst);
    wb(1'b1, OFS_CTRL, 32'h1);
    wb(1'b1, OFS_ADV, 32'h1234);
    wb(1'b1, OFS_LANE, 32'h3c);
    wb(1'b1, OFS_COEF, 32'h2d6);
    repeat (3) @(negedge clk);
    chk("reg codeword", 32'h1234, cw);
    chk("reg preset", 32'hc, fp);
    chk("reg init", 32'h3, fi);
    chk("reg update", 32'h16, fu);
    chk("reg status", 32'hb, fs);
    wb(1'b0, OFS_ADV, 32'h0);
    chk("adv read", 32'h1234, q);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status read", 32'h40, q);
    wb(1'b1, OFS_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    chk("pin codeword", 32'h2d56, cw);
    $display("test regs done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    t_reset;
    t_pins;
    t_train;
    t_regs;
    print_verdict;
  end
endmodule
